/* File: hdl/dop_pkg.sv */
// Constants, register layout and carrier types for the display output port conditioning block.
`default_nettype none

package dop_pkg;

    // ==========================================================
    // Register map (byte addresses, low twelve address bits)
    // ==========================================================
    localparam logic [11:0] DOP_ADDR_PORT1 = 12'h044;
    localparam logic [11:0] DOP_ADDR_PORT2 = 12'h048;
    localparam logic [11:0] DOP_ADDR_STATUS = 12'h04C;

    // ==========================================================
    // Field positions within the port control words and the status word
    // ==========================================================
    localparam int DOP_BIT_SEL = 0;
    localparam int DOP_BIT_BLANK_POL = 1;
    localparam int DOP_BIT_VPOL = 3;
    localparam int DOP_BIT_HPOL = 4;
    localparam int DOP_BIT_CLK_INV = 5;
    localparam int DOP_BIT_DELAY_LO = 6;
    localparam int DOP_BIT_DEEP = 8;
    localparam int DOP_BIT_DDR = 9;
    localparam int DOP_BIT_STAT_RUNNING = 0;
    localparam int DOP_BIT_STAT_PENDING = 1;

    // Writable bits of each control word; all other bits read as zero.
    localparam logic [31:0] DOP_PORT1_MASK = 32'h0000_00D9;
    localparam logic [31:0] DOP_PORT2_MASK = 32'h0000_03FB;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [31:0] DOP_PORT1_RESET = 32'h0000_0000;
    localparam logic [31:0] DOP_PORT2_RESET = 32'h0000_0020;

    // ==========================================================
    // Widths and bus encodings
    // ==========================================================
    localparam int DOP_DATA_W = 24;
    localparam int DOP_DDR_W = 15;
    localparam logic [1:0] DOP_HTRANS_NONSEQ = 2'h2;
    localparam logic DOP_HRESP_OKAY = 1'b0;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed {
        logic hsync;
        logic vsync;
        logic blank;
        logic [DOP_DATA_W-1:0] data;
    } dop_video_type;

    typedef struct packed {
        logic ddr;
        logic deep;
        logic [1:0] delay;
        logic clk_inv;
        logic hpol;
        logic vpol;
        logic blank_pol;
        logic sel;
    } dop_port_cfg_type;

    function automatic dop_port_cfg_type dop_decode(input logic [31:0] word);
        dop_port_cfg_type cfg;
        cfg.ddr = word[DOP_BIT_DDR];
        cfg.deep = word[DOP_BIT_DEEP];
        cfg.delay = word[DOP_BIT_DELAY_LO+1 -: 2];
        cfg.clk_inv = word[DOP_BIT_CLK_INV];
        cfg.hpol = word[DOP_BIT_HPOL];
        cfg.vpol = word[DOP_BIT_VPOL];
        cfg.blank_pol = word[DOP_BIT_BLANK_POL];
        cfg.sel = word[DOP_BIT_SEL];
        return cfg;
    endfunction

endpackage

`default_nettype wire

/* File: hdl/dop_port_conditioning.sv */
// Output conditioning for two display output ports with an AHB-Lite control slave.
`default_nettype none

// ==========================================================
// Sync delay pipeline, one per port
// ==========================================================
module dop_sync_delay (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] sync_in,
    input wire logic [1:0] delay,
    input wire logic idle,
    input wire logic [1:0] idle_level,
    output logic [1:0] sync_out
);
    logic [1:0] stage0;
    logic [1:0] stage1;
    logic [1:0] stage2;
    wire logic [1:0] tap;

    // The input is already polarised, so both syncs shift together.
    assign tap = (delay == 2'h0) ? sync_in :
                 (delay == 2'h1) ? stage0 :
                 (delay == 2'h2) ? stage1 : stage2;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage0 <= 2'h3;
            stage1 <= 2'h3;
            stage2 <= 2'h3;
            sync_out <= 2'h3;
        end else begin
            stage0 <= sync_in;
            stage1 <= stage0;
            stage2 <= stage1;
            // Deselection bypasses the pipeline so it takes effect at once.
            sync_out <= idle ? idle_level : tap;
        end
    end
endmodule // dop_sync_delay

// ==========================================================
// Top level
// ==========================================================
module dop_port_conditioning import dop_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pix_clk,
    input wire dop_video_type vid_in,
    input wire logic controller_running_flag,
    output dop_video_type port1_out,
    output logic port1_clk,
    output dop_video_type port2_out,
    output logic port2_clk
);

    // ==========================================================
    // Bus slave
    // ==========================================================
    logic dph_write;
    logic [11:0] dph_addr;
    logic [31:0] output_port_one_control;
    logic [31:0] output_port_two_control;
    logic running_meta;
    logic running_sync;
    logic cfg_dirty;
    logic req_tgl;
    logic ack_meta;
    logic ack_sync;
    // Pixel-domain echo of the request toggle; declared here because the bus side reads it.
    logic req_seen;
    dop_port_cfg_type snap1;
    dop_port_cfg_type snap2;

    wire logic addr_phase = hsel & hready & htrans[1];
    wire logic wr_port1 = dph_write && (dph_addr == DOP_ADDR_PORT1);
    wire logic wr_port2 = dph_write && (dph_addr == DOP_ADDR_PORT2);
    wire logic [31:0] next_port1 = wr_port1 ? (hwdata & DOP_PORT1_MASK) : output_port_one_control;
    wire logic [31:0] next_port2 = wr_port2 ? (hwdata & DOP_PORT2_MASK) : output_port_two_control;
    wire logic launch = cfg_dirty && (req_tgl == ack_sync);
    wire logic pending = cfg_dirty || (req_tgl != ack_sync);
    wire logic [31:0] status_word = {30'h0, pending, running_sync};
    wire logic [11:0] rd_addr = haddr[11:0];
    wire logic [31:0] rd_word;

    // Reads see a write from the immediately preceding transfer.
    assign rd_word = (rd_addr == DOP_ADDR_PORT1) ? next_port1 :
                     (rd_addr == DOP_ADDR_PORT2) ? next_port2 :
                     (rd_addr == DOP_ADDR_STATUS) ? status_word : 32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp = DOP_HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_write <= 1'b0;
            dph_addr <= 12'h000;
            hrdata <= 32'h0000_0000;
        end else begin
            dph_write <= addr_phase & hwrite;
            dph_addr <= rd_addr;
            hrdata <= (addr_phase && !hwrite) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_port_one_control <= DOP_PORT1_RESET;
            output_port_two_control <= DOP_PORT2_RESET;
        end else begin
            output_port_one_control <= next_port1;
            output_port_two_control <= next_port2;
        end
    end

    // Status reflects the controller flag so software can honour the stop-first advice.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            running_meta <= 1'b0;
            running_sync <= 1'b0;
        end else begin
            running_meta <= controller_running_flag;
            running_sync <= running_meta;
        end
    end

    // ==========================================================
    // Configuration crossing, toggle handshake
    // ==========================================================
    // A write landing in the launch cycle keeps the dirty flag set and is resent.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_dirty <= 1'b0;
            req_tgl <= 1'b0;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            snap1 <= dop_decode(DOP_PORT1_RESET);
            snap2 <= dop_decode(DOP_PORT2_RESET);
        end else begin
            cfg_dirty <= wr_port1 | wr_port2 | (cfg_dirty & ~launch);
            ack_meta <= req_seen;
            ack_sync <= ack_meta;
            if (launch) begin
                req_tgl <= ~req_tgl;
                snap1 <= dop_decode(output_port_one_control);
                snap2 <= dop_decode(output_port_two_control);
            end
        end
    end

    // ==========================================================
    // Pixel clock domain
    // ==========================================================
    logic pix_rst_meta;
    logic pix_rstn;
    logic req_meta;
    logic req_sync;
    dop_port_cfg_type cfg1;
    dop_port_cfg_type cfg2;

    always_ff @(posedge pix_clk or negedge hresetn) begin
        if (!hresetn) begin
            pix_rst_meta <= 1'b0;
            pix_rstn <= 1'b0;
        end else begin
            pix_rst_meta <= 1'b1;
            pix_rstn <= pix_rst_meta;
        end
    end

    // The snapshot is held steady from launch until the acknowledge returns.
    always_ff @(posedge pix_clk or negedge pix_rstn) begin
        if (!pix_rstn) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_seen <= 1'b0;
            cfg1 <= dop_decode(DOP_PORT1_RESET);
            cfg2 <= dop_decode(DOP_PORT2_RESET);
        end else begin
            req_meta <= req_tgl;
            req_sync <= req_meta;
            req_seen <= req_sync;
            if (req_sync != req_seen) begin
                cfg1 <= snap1;
                cfg2 <= snap2;
            end
        end
    end

    // ==========================================================
    // Port 1: sync, blank, data and clock
    // ==========================================================
    logic p1_blank;
    logic [DOP_DATA_W-1:0] p1_data;
    logic [1:0] p1_sync;
    wire logic p1_hs_pol = (vid_in.hsync & cfg1.sel) ~^ cfg1.hpol;
    wire logic p1_vs_pol = (vid_in.vsync & cfg1.sel) ~^ cfg1.vpol;

    dop_sync_delay u_p1_delay (
        .clk(pix_clk),
        .rstn(pix_rstn),
        .sync_in({p1_vs_pol, p1_hs_pol}),
        .delay(cfg1.delay),
        .idle(~cfg1.sel),
        .idle_level({~cfg1.vpol, ~cfg1.hpol}),
        .sync_out(p1_sync)
    );

    always_ff @(posedge pix_clk or negedge pix_rstn) begin
        if (!pix_rstn) begin
            p1_blank <= 1'b1;
            p1_data <= '0;
        end else begin
            p1_blank <= ~cfg1.sel | vid_in.blank;
            p1_data <= cfg1.sel ? vid_in.data : '0;
        end
    end

    assign port1_out = {p1_sync[0], p1_sync[1], p1_blank, p1_data};
    // Gated by a pixel-domain flop; changes only after the crossing settles.
    assign port1_clk = cfg1.sel & pix_clk;

    // ==========================================================
    // Port 2: sync, blank, single or double rate data and clock
    // ==========================================================
    logic p2_blank;
    logic [DOP_DATA_W-1:0] p2_word;
    logic [DOP_DDR_W-1:0] p2_first;
    logic [DOP_DDR_W-1:0] p2_second;
    logic [1:0] p2_sync;
    wire logic p2_hs_pol = (vid_in.hsync & cfg2.sel) ~^ cfg2.hpol;
    wire logic p2_vs_pol = (vid_in.vsync & cfg2.sel) ~^ cfg2.vpol;
    wire logic p2_live = cfg2.sel & cfg2.ddr;
    wire logic [DOP_DDR_W-1:0] next_first =
        cfg2.deep ? vid_in.data[23:9] : {3'h0, vid_in.data[23:12]};
    wire logic [DOP_DDR_W-1:0] next_second =
        cfg2.deep ? {vid_in.data[8:0], 6'h00} : {3'h0, vid_in.data[11:0]};
    wire logic [DOP_DDR_W-1:0] ddr_half = pix_clk ? p2_first : p2_second;
    wire logic p2_clk_flip = ~cfg2.ddr & cfg2.clk_inv;

    dop_sync_delay u_p2_delay (
        .clk(pix_clk),
        .rstn(pix_rstn),
        .sync_in({p2_vs_pol, p2_hs_pol}),
        .delay(cfg2.delay),
        .idle(~cfg2.sel),
        .idle_level({~cfg2.vpol, ~cfg2.hpol}),
        .sync_out(p2_sync)
    );

    always_ff @(posedge pix_clk or negedge pix_rstn) begin
        if (!pix_rstn) begin
            p2_blank <= 1'b0;
            p2_word <= '0;
            p2_first <= '0;
            p2_second <= '0;
        end else begin
            p2_blank <= (~cfg2.sel | vid_in.blank) ~^ cfg2.blank_pol;
            p2_word <= (cfg2.sel & ~cfg2.ddr) ? vid_in.data : '0;
            p2_first <= p2_live ? next_first : '0;
            p2_second <= p2_live ? next_second : '0;
        end
    end

    // The first half word fills the high phase, the second the low phase.
    assign port2_out = {p2_sync[0], p2_sync[1], p2_blank,
                        cfg2.ddr ? {9'h000, ddr_half} : p2_word};
    // At single rate, inversion puts the rising edge mid-period; otherwise it matches the launch edge.
    assign port2_clk = cfg2.sel & (pix_clk ^ p2_clk_flip);

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb_pix @(posedge pix_clk);
    endclocking
    default disable iff (!pix_rstn);

    property p_p1_delay;
        (cfg1.sel && cfg1.delay == 2'h3)[*5] |-> p1_sync[0] == $past(p1_hs_pol, 4);
    endproperty
    a_p1_delay: assert property (p_p1_delay) else $error("port 1 hsync delay wrong");

    property p_p2_delay;
        (cfg2.sel && cfg2.delay == 2'h1)[*3] |-> p2_sync[1] == $past(p2_vs_pol, 2);
    endproperty
    a_p2_delay: assert property (p_p2_delay) else $error("port 2 vsync delay wrong");

    property p_p1_hpol;
        cfg1.sel && cfg1.delay == 2'h0 && vid_in.hsync ##1 cfg1.sel && cfg1.delay == 2'h0
            |-> p1_sync[0] == cfg1.hpol;
    endproperty
    a_p1_hpol: assert property (p_p1_hpol) else $error("port 1 hsync level wrong");

    property p_p1_vpol;
        cfg1.sel && cfg1.delay == 2'h0 && !vid_in.vsync ##1 cfg1.sel && cfg1.delay == 2'h0
            |-> p1_sync[1] == !cfg1.vpol;
    endproperty
    a_p1_vpol: assert property (p_p1_vpol) else $error("port 1 vsync idle level wrong");

    property p_p1_idle;
        !cfg1.sel |=> p1_blank && p1_data == '0 && p1_sync == {!$past(cfg1.vpol), !$past(cfg1.hpol)};
    endproperty
    a_p1_idle: assert property (p_p1_idle) else $error("port 1 not idle when deselected");

    property p_p1_live;
        cfg1.sel |=> p1_data == $past(vid_in.data);
    endproperty
    a_p1_live: assert property (p_p1_live) else $error("port 1 data not live");

    property p_p2_off_now;
        $fell(cfg2.sel) |-> ##1 p2_blank == cfg2.blank_pol && port2_out.data == '0;
    endproperty
    a_p2_off_now: assert property (p_p2_off_now) else $error("port 2 deselect not immediate");

    property p_p2_narrow;
        cfg2.sel && cfg2.ddr && !cfg2.deep |=> p2_first[14:12] == 3'h0 && p2_second[14:12] == 3'h0;
    endproperty
    a_p2_narrow: assert property (p_p2_narrow) else $error("port 2 narrow word too wide");

    property p_p2_ddr_pair;
        cfg2.sel && cfg2.ddr && cfg2.deep |=> {p2_first, p2_second[14:6]} == $past(vid_in.data);
    endproperty
    a_p2_ddr_pair: assert property (p_p2_ddr_pair) else $error("port 2 double rate split wrong");

    property p_p2_blank;
        cfg2.sel && vid_in.blank ##1 cfg2.sel |-> p2_blank == cfg2.blank_pol;
    endproperty
    a_p2_blank: assert property (p_p2_blank) else $error("port 2 blank polarity wrong");

    property p_p2_sdr_live;
        cfg2.sel && !cfg2.ddr ##1 cfg2.sel && !cfg2.ddr |-> port2_out.data == $past(vid_in.data);
    endproperty
    a_p2_sdr_live: assert property (p_p2_sdr_live) else $error("port 2 data not live");

endmodule // dop_port_conditioning

`default_nettype wire

/* File: verif/dop_rgb_sink.sv */
// Receiver model of the external digital RGB chip on port 2.
`default_nettype none

module dop_rgb_sink (
    input wire logic rx_clk,
    input wire logic [23:0] rx_data,
    output logic [14:0] first_half,
    output logic [14:0] second_half
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Capture
    // ==========================================================
    // Each half is taken in mid-phase, as a receiver with centred setup would do.
    // Sampling on the edge itself would race the halves that switch with the clock level.
    initial begin
        first_half = 15'h0;
        second_half = 15'h0;
    end

    always begin
        @(posedge rx_clk);
        #3;
        first_half = rx_data[14:0];
        @(negedge rx_clk);
        #3;
        second_half = rx_data[14:0];
    end
endmodule // dop_rgb_sink

`default_nettype wire

/* File: verif/tb.sv */
// Self-checking testbench for the display output port conditioning block.
`default_nettype none

module tb import dop_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [23:0] PIX = 24'hA5C3F0;
    logic hclk = 1'b0;
    logic pix_clk;
    logic hresetn, hsel, hwrite, running, hreadyout, hresp, port1_clk, port2_clk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [14:0] first_half, second_half;
    dop_video_type vid_in, port1_out, port2_out;
    int n_mismatch = 0;
    int compares = 0;

    // ==========================================================
    // Clocks, design and receiver
    // ==========================================================
    always #50 hclk = ~hclk;

    // The odd start offset keeps pixel edges from ever meeting bus edges.
    initial begin
        pix_clk = 1'b0;
        #3.7;
        forever #6 pix_clk = ~pix_clk;
    end

    dop_port_conditioning u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pix_clk(pix_clk),
        .vid_in(vid_in), .controller_running_flag(running), .port1_out(port1_out),
        .port1_clk(port1_clk), .port2_out(port2_out), .port2_clk(port2_clk));

    dop_rgb_sink u_sink (.rx_clk(port2_clk), .rx_data(port2_out.data),
        .first_half(first_half), .second_half(second_half));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rdv);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= DOP_HTRANS_NONSEQ;
        haddr <= {20'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        chk({31'h0, hresp}, {31'h0, DOP_HRESP_OKAY});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        chk(rd, exp);
    endtask

    // Each setting is written, then the status pending bit is polled until the crossing completes.
    task automatic cfg(input logic [11:0] a, input logic [31:0] v);
        int n;
        bus(1'b1, a, v, rd);
        n = 0;
        do begin
            bus(1'b0, DOP_ADDR_STATUS, 32'h0, rd);
            n++;
        end while (rd[DOP_BIT_STAT_PENDING] !== 1'b0 && n < 50);
        chk({31'h0, rd[DOP_BIT_STAT_PENDING]}, 32'h0);
        repeat (4) @(posedge pix_clk);
    endtask

    task automatic conclude;
        $display("summary: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #500000;
        n_mismatch++;
        $display("watchdog expired");
        conclude();
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        logic [1:0] dl;
        logic hp;
        logic vp;
        logic bb;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        running = 1'b0;
        vid_in = '0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge pix_clk);
        #3;
        chk({5'h0, port1_out}, 32'h0700_0000);
        chk({5'h0, port2_out}, 32'h0600_0000);
        chk({30'h0, port1_clk, port2_clk}, 32'h0);
        $display("test idle after reset done");

        rd_chk(DOP_ADDR_PORT1, DOP_PORT1_RESET);
        rd_chk(DOP_ADDR_PORT2, DOP_PORT2_RESET);
        bus(1'b1, DOP_ADDR_PORT1, 32'hFFFF_FFFF, rd);
        rd_chk(DOP_ADDR_PORT1, DOP_PORT1_MASK);
        bus(1'b1, DOP_ADDR_PORT2, 32'hFFFF_FFFF, rd);
        rd_chk(DOP_ADDR_PORT2, DOP_PORT2_MASK);
        bus(1'b1, 12'h100, 32'hFFFF_FFFF, rd);
        rd_chk(12'h100, 32'h0);
        cfg(DOP_ADDR_PORT1, 32'h0);
        cfg(DOP_ADDR_PORT2, 32'h0);
        running <= 1'b1;
        repeat (3) @(posedge hclk);
        rd_chk(DOP_ADDR_STATUS, 32'h1);
        running <= 1'b0;
        $display("test registers done");

        for (int d = 0; d < 4; d++) begin
            dl = 2'(d);
            hp = dl[0];
            vp = ~dl[0];
            cfg(DOP_ADDR_PORT1, {24'h0, dl, 1'b0, hp, vp, 3'h1});
            cfg(DOP_ADDR_PORT2, {24'h0, dl, 1'b0, ~hp, ~vp, 3'h1});
            @(posedge pix_clk);
            vid_in <= {3'b110, PIX};
            for (int i = 1; i < 6; i++) begin
                @(posedge pix_clk);
                vid_in <= '0;
                #1;
                chk({30'h0, port1_out.hsync, port1_out.vsync},
                    {30'h0, (i == d + 1) ? {hp, vp} : {~hp, ~vp}});
                chk({30'h0, port2_out.hsync, port2_out.vsync},
                    {30'h0, (i == d + 1) ? {~hp, ~vp} : {hp, vp}});
                chk({8'h0, port1_out.data}, (i == 1) ? {8'h0, PIX} : 32'h0);
                chk({8'h0, port2_out.data}, (i == 1) ? {8'h0, PIX} : 32'h0);
                chk({30'h0, port1_clk, port2_clk}, 32'h3);
            end
        end
        $display("test sync delay and polarity done");

        for (int b = 0; b < 2; b++) begin
            bb = 1'(b);
            cfg(DOP_ADDR_PORT1, 32'h1);
            cfg(DOP_ADDR_PORT2, {30'h8, bb, 1'b1});
            @(posedge pix_clk);
            vid_in <= {3'b001, PIX};
            repeat (2) @(posedge pix_clk);
            #3;
            chk({30'h0, port2_out.blank, port1_out.blank}, {30'h0, bb, 1'b1});
            chk({30'h0, port1_clk, port2_clk}, 32'h2);
            @(posedge pix_clk);
            vid_in <= '0;
            repeat (2) @(posedge pix_clk);
            #3;
            chk({30'h0, port2_out.blank, port1_out.blank}, {30'h0, ~bb, 1'b0});
        end
        $display("test blank polarity and clock inversion done");

        for (int dp = 0; dp < 2; dp++) begin
            cfg(DOP_ADDR_PORT2, (dp != 0) ? 32'h0000_0321 : 32'h0000_0221);
            @(posedge pix_clk);
            vid_in <= {3'b000, PIX};
            repeat (4) @(posedge pix_clk);
            #5;
            chk({31'h0, port2_clk}, 32'h1);
            chk({17'h0, first_half},
                (dp != 0) ? {17'h0, PIX[23:9]} : {20'h0, PIX[23:12]});
            chk({17'h0, second_half},
                (dp != 0) ? {17'h0, PIX[8:0], 6'h0} : {20'h0, PIX[11:0]});
        end
        $display("test double rate done");

        @(posedge pix_clk);
        vid_in <= {3'b110, PIX};
        cfg(DOP_ADDR_PORT2, 32'h0000_0002);
        cfg(DOP_ADDR_PORT1, 32'h0);
        #3;
        chk({5'h0, port1_out}, 32'h0700_0000);
        chk({5'h0, port2_out}, 32'h0700_0000);
        chk({30'h0, port1_clk, port2_clk}, 32'h0);
        $display("test deselect done");
        conclude();
    end
endmodule // tb

`default_nettype wire
